// ==== logic/hpc_pkg.sv ====
// constants and carrier types of the host port page and config registers
package hpc_pkg;

    localparam int PAGE_W = 8;
    localparam int OFS_W = 7;
    localparam int DATA_W = 8;
    localparam int ADDR_W = PAGE_W + OFS_W;

    // offsets inside a 128-byte page
    localparam logic [OFS_W-1:0] OFS_CLK_STATUS = 7'h32;
    localparam logic [OFS_W-1:0] OFS_CFG_DONE = 7'h33;
    localparam logic [OFS_W-1:0] OFS_BUS_ADDR = 7'h3e;
    localparam logic [OFS_W-1:0] OFS_PORT_CTRL = 7'h7e;
    localparam logic [OFS_W-1:0] OFS_PAGE_SEL = 7'h7f;

    localparam logic [PAGE_W-1:0] LOCAL_PAGE = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 8'h0f;

    // field positions
    localparam int CFG_READY_BIT = 0;
    localparam int LOCKOUT_BIT = 7;
    localparam int STATUS_BIT = 0;
    localparam int BUS_ADDR_LSB = 1;
    localparam int BUS_ADDR_MSB = 6;

    // reset values
    localparam logic [DATA_W-1:0] CFG_DONE_RST = 8'h00;
    localparam logic [DATA_W-1:0] BUS_ADDR_RST = 8'h38;
    localparam logic [DATA_W-1:0] PORT_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] PAGE_SEL_RST = 8'h00;

    // order gives codes 00, 01, 10, 11
    typedef enum logic [1:0] {
        SC_NOT_STARTED,
        SC_WAIT_HOST,
        SC_IN_PROGRESS,
        SC_READY
    } hpc_clk_state_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [OFS_W-1:0] offset;
        logic [DATA_W-1:0] wdata;
    } hpc_host_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [DATA_W-1:0] rdata;
    } hpc_host_rsp_type;

    typedef struct packed {
        logic req;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hpc_ext_req_type;

endpackage

// ==== logic/hpc_first_rise.sv ====
// one-shot detector for the first rising edge after reset
`timescale 1ns/1ps
`default_nettype none
module hpc_first_rise (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    output logic pulse_o,
    output logic spent_o
);

    logic prev_q;
    logic spent_q;
    logic pulse_q;
    logic rise;

    assign rise = level_i & ~prev_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_i;
        end
    end

    // later edges are ignored until the next reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spent_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= rise & ~spent_q;
            if (rise) begin
                spent_q <= 1'b1;
            end
        end
    end

    assign pulse_o = pulse_q;
    assign spent_o = spent_q;

endmodule
`default_nettype wire

// ==== logic/hpc_regs.sv ====
// host port page select, lockout, status and config-done registers
`timescale 1ns/1ps
`default_nettype none
module hpc_regs
    import hpc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire hpc_host_req_type host_req_i,
    output hpc_host_rsp_type host_rsp_o,
    output hpc_ext_req_type ext_req_o,
    input wire logic [DATA_W-1:0] ext_rdata_i,
    input wire logic ext_err_i,
    input wire logic i2c_mode_i,
    input wire logic [BUS_ADDR_MSB-BUS_ADDR_LSB:0] bus_addr_i,
    input wire logic sysclk_ready_i,
    output logic cfg_latch_o,
    output logic cfg_latched_o,
    output logic [PAGE_W-1:0] page_o,
    output logic write_locked_o,
    output hpc_clk_state_type clk_state_o
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic [DATA_W-1:0] cfg_done_q;
    logic [DATA_W-1:0] bus_addr_q;
    logic lockout_q;
    logic status_q;
    logic [PAGE_W-1:0] page_q;
    hpc_clk_state_type state_q;
    hpc_host_rsp_type rsp_q;
    logic addr_loaded_q;

    logic is_ctrl;
    logic is_page;
    logic is_global;
    logic on_local;
    logic page_ok;
    logic is_cfg;
    logic is_stat;
    logic is_addr;
    logic is_local;
    logic fail;
    logic ext_hit;
    logic wr_ok;
    logic [DATA_W-1:0] rdata_d;

    assign is_ctrl = host_req_i.offset == OFS_PORT_CTRL;
    assign is_page = host_req_i.offset == OFS_PAGE_SEL;
    assign is_global = is_ctrl | is_page;
    assign on_local = page_q == LOCAL_PAGE;
    assign page_ok = page_q <= PAGE_LAST;
    assign is_cfg = on_local & (host_req_i.offset == OFS_CFG_DONE);
    assign is_stat = on_local & (host_req_i.offset == OFS_CLK_STATUS);
    assign is_addr = on_local & (host_req_i.offset == OFS_BUS_ADDR);
    assign is_local = is_cfg | is_stat | is_addr;

    // the control register stays writable, else lockout could never clear
    always_comb begin
        fail = 1'b0;
        if (host_req_i.write && lockout_q && !is_ctrl) begin
            fail = 1'b1;
        end
        if (!is_global && !page_ok) begin
            fail = 1'b1;
        end
        if (host_req_i.write && (is_stat || is_addr)) begin
            fail = 1'b1;
        end
    end

    assign wr_ok = host_req_i.valid & host_req_i.write & ~fail;
    assign ext_hit = host_req_i.valid & ~is_global & ~is_local & ~fail;

    // rest of the map is reached at page joined to offset
    always_comb begin
        ext_req_o.req = ext_hit;
        ext_req_o.write = host_req_i.write;
        ext_req_o.addr = {page_q, host_req_i.offset};
        ext_req_o.wdata = host_req_i.wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_q <= PAGE_SEL_RST;
        end else if (wr_ok && is_page) begin
            page_q <= host_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_done_q <= CFG_DONE_RST;
        end else if (wr_ok && is_cfg) begin
            cfg_done_q <= '0;
            cfg_done_q[CFG_READY_BIT] <= host_req_i.wdata[CFG_READY_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lockout_q <= PORT_CTRL_RST[LOCKOUT_BIT];
        end else if (wr_ok && is_ctrl) begin
            lockout_q <= host_req_i.wdata[LOCKOUT_BIT];
        end
    end

    // reads of the control register keep the result of the access before
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_q <= PORT_CTRL_RST[STATUS_BIT];
        end else if (host_req_i.valid && !is_ctrl) begin
            status_q <= fail | (ext_hit & ext_err_i);
        end
    end

    // strap is same-clock logic, picked up once after reset release in i2c mode only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_addr_q <= BUS_ADDR_RST;
            addr_loaded_q <= 1'b0;
        end else if (!addr_loaded_q) begin
            addr_loaded_q <= 1'b1;
            if (i2c_mode_i) begin
                bus_addr_q <= '0;
                bus_addr_q[BUS_ADDR_MSB:BUS_ADDR_LSB] <= bus_addr_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config capture and clock state

    // host keeps the clear, write, set order; only the first set counts
    hpc_first_rise u_first_rise (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(cfg_done_q[CFG_READY_BIT]),
        .pulse_o(cfg_latch_o),
        .spent_o(cfg_latched_o)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= SC_NOT_STARTED;
        end else begin
            unique case (state_q)
                SC_NOT_STARTED: begin
                    state_q <= SC_WAIT_HOST;
                end
                SC_WAIT_HOST: begin
                    if (cfg_latch_o) begin
                        state_q <= SC_IN_PROGRESS;
                    end
                end
                SC_IN_PROGRESS: begin
                    if (sysclk_ready_i) begin
                        state_q <= SC_READY;
                    end
                end
                SC_READY: begin
                    state_q <= SC_READY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and answer

    always_comb begin
        rdata_d = '0;
        if (is_ctrl) begin
            rdata_d[LOCKOUT_BIT] = lockout_q;
            rdata_d[STATUS_BIT] = status_q;
        end else if (is_page) begin
            rdata_d = page_q;
        end else if (is_cfg) begin
            rdata_d = cfg_done_q;
        end else if (is_stat) begin
            rdata_d[1:0] = state_q;
        end else if (is_addr) begin
            rdata_d = bus_addr_q;
        end else if (ext_hit) begin
            rdata_d = ext_rdata_i;
        end
    end

    // one-cycle answer; failed reads return zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack <= host_req_i.valid;
            rsp_q.err <= host_req_i.valid & (fail | (ext_hit & ext_err_i));
            if (host_req_i.valid && !host_req_i.write) begin
                rsp_q.rdata <= fail ? '0 : rdata_d;
            end
        end
    end

    assign host_rsp_o = rsp_q;
    assign page_o = page_q;
    assign write_locked_o = lockout_q;
    assign clk_state_o = state_q;

endmodule
`default_nettype wire

// ==== dv/hpc_regs_chk.sv ====
// concurrent checks on the host port register ports
`timescale 1ns/1ps
`default_nettype none
module hpc_regs_chk
    import hpc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire hpc_host_req_type host_req_i,
    input wire hpc_host_rsp_type host_rsp_o,
    input wire hpc_ext_req_type ext_req_o,
    input wire logic ext_err_i,
    input wire logic sysclk_ready_i,
    input wire logic cfg_latch_o,
    input wire logic cfg_latched_o,
    input wire logic [PAGE_W-1:0] page_o,
    input wire logic write_locked_o,
    input wire hpc_clk_state_type clk_state_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic wr, ctl, glb;
    assign wr = host_req_i.valid && host_req_i.write;
    assign ctl = host_req_i.offset == OFS_PORT_CTRL;
    assign glb = ctl || host_req_i.offset == OFS_PAGE_SEL;
    chk_ack_timing: assert property (
        host_rsp_o.ack == $past(host_req_i.valid)) else $error("bad ack");
    chk_page_store: assert property (
        wr && host_req_i.offset == OFS_PAGE_SEL && !write_locked_o
        |=> page_o == $past(host_req_i.wdata)) else $error("page lost");
    chk_lock_refuse: assert property (
        wr && write_locked_o && !ctl |=> host_rsp_o.err && $stable(page_o))
        else $error("locked write taken");
    chk_ext_addr: assert property (
        ext_req_o.req |-> ext_req_o.addr == {page_o, host_req_i.offset})
        else $error("bad ext address");
    chk_rsvd_page: assert property (
        host_req_i.valid && page_o > PAGE_LAST && !glb
        |-> !ext_req_o.req ##1 host_rsp_o.err) else $error("reserved page");
    chk_ext_fault: assert property (
        ext_req_o.req && ext_err_i |=> host_rsp_o.err)
        else $error("ext fault lost");
    chk_one_latch: assert property (
        $past(cfg_latched_o) |-> !cfg_latch_o) else $error("second latch");
    chk_latch_state: assert property (
        cfg_latch_o |-> cfg_latched_o ##1 clk_state_o == SC_IN_PROGRESS)
        else $error("latch state");
    chk_ready_state: assert property (
        clk_state_o == SC_IN_PROGRESS && sysclk_ready_i
        |=> clk_state_o == SC_READY) else $error("not ready");
endmodule
bind hpc_regs hpc_regs_chk u_chk (.clk_i, .rst_n_i, .host_req_i,
    .host_rsp_o, .ext_req_o, .ext_err_i, .sysclk_ready_i, .cfg_latch_o,
    .cfg_latched_o, .page_o, .write_locked_o, .clk_state_o);
`default_nettype wire

// ==== dv/hpc_map_model.sv ====
// rest-of-map responder behind the ext port
`timescale 1ns/1ps
`default_nettype none
module hpc_map_model
    import hpc_pkg::*;
(
    input wire logic clk_i,
    input wire hpc_ext_req_type ext_req_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic err_o
);
    logic [DATA_W-1:0] last_q;
    // data tied to the low eight address bits, idle data flips off the last value, idle err copies its bit 0
    assign rdata_o = ext_req_i.req ? ext_req_i.addr[7:0] ^ 8'h5a : ~last_q;
    assign err_o = ext_req_i.req ? ext_req_i.addr[6:0] == 7'h7d : last_q[0];
    always_ff @(posedge clk_i) begin
        if (ext_req_i.req) last_q <= rdata_o;
    end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the host port registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import hpc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic i2c = 1'b0;
    logic rdy = 1'b0;
    logic lat, latd, lck, xer;
    logic [7:0] pg, xrd;
    hpc_host_req_type req = '0;
    hpc_host_rsp_type rsp;
    hpc_ext_req_type xrq;
    hpc_clk_state_type st;
    int error_cnt = 0;
    int comparisons = 0;
    int n_lat = 0;
    hpc_regs uut (.clk_i, .rst_n_i, .host_req_i(req), .host_rsp_o(rsp),
        .ext_req_o(xrq), .ext_rdata_i(xrd), .ext_err_i(xer),
        .i2c_mode_i(i2c), .bus_addr_i(6'h15), .sysclk_ready_i(rdy),
        .cfg_latch_o(lat), .cfg_latched_o(latd), .page_o(pg),
        .write_locked_o(lck), .clk_state_o(st));
    hpc_map_model u_map (.clk_i, .ext_req_i(xrq), .rdata_o(xrd),
        .err_o(xer));
    initial forever #2 clk_i = ~clk_i;
    // counted mid-cycle so the one-cycle pulse is never raced
    always @(negedge clk_i) if (lat === 1'b1) n_lat++;
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access; for reads d is the expected data
    task automatic acc(logic w, logic [6:0] o, logic [7:0] d, logic e);
        @(negedge clk_i);
        req <= '{1'b1, w, o, w ? d : 8'h00};
        // ack stands only between the taking edge and the edge after it
        @(negedge clk_i);
        chk("ack_err", {6'h0, 1'b1, e}, {6'h0, rsp.ack, rsp.err});
        if (!w) chk("rdata", d, rsp.rdata);
        req <= '0;
    endtask
    task automatic t_reset(logic m, logic [7:0] a);
        @(negedge clk_i);
        rst_n_i <= 1'b0;
        i2c <= m;
        rdy <= 1'b0;
        repeat (5) @(negedge clk_i);
        rst_n_i <= 1'b1;
        acc(1'b0, 7'h33, 8'h00, 1'b0);
        acc(1'b0, 7'h3e, a, 1'b0);
        acc(1'b0, 7'h7e, 8'h00, 1'b0);
        acc(1'b0, 7'h7f, 8'h00, 1'b0);
        acc(1'b0, 7'h32, 8'h01, 1'b0);
    endtask
    task automatic t_page();
        acc(1'b1, 7'h7f, 8'h02, 1'b0);
        acc(1'b0, 7'h10, 8'h4a, 1'b0);
        acc(1'b1, 7'h7f, 8'h0f, 1'b0);
        acc(1'b0, 7'h00, 8'hda, 1'b0);
        acc(1'b0, 7'h7d, 8'ha7, 1'b1);
        acc(1'b1, 7'h7f, 8'h10, 1'b0);
        acc(1'b0, 7'h33, 8'h00, 1'b1);
        acc(1'b0, 7'h7e, 8'h01, 1'b0);
        acc(1'b1, 7'h7f, 8'h00, 1'b0);
        acc(1'b0, 7'h33, 8'h00, 1'b0);
        acc(1'b0, 7'h7e, 8'h00, 1'b0);
    endtask
    task automatic t_lock();
        acc(1'b1, 7'h7e, 8'h80, 1'b0);
        acc(1'b1, 7'h7f, 8'h05, 1'b1);
        acc(1'b1, 7'h33, 8'h01, 1'b1);
        chk("page", 8'h00, pg);
        acc(1'b0, 7'h7e, 8'h81, 1'b0);
        acc(1'b1, 7'h7e, 8'h00, 1'b0);
        chk("lock", 8'h00, {7'h0, lck});
        acc(1'b1, 7'h3e, 8'hff, 1'b1);
        acc(1'b0, 7'h33, 8'h00, 1'b0);
    endtask
    task automatic t_cfg();
        acc(1'b1, 7'h33, 8'h00, 1'b0);
        acc(1'b1, 7'h33, 8'hff, 1'b0);
        repeat (2) @(negedge clk_i);
        chk("latches", 8'h01, n_lat[7:0]);
        chk("latched", 8'h01, {7'h0, latd});
        acc(1'b0, 7'h32, 8'h02, 1'b0);
        acc(1'b0, 7'h33, 8'h01, 1'b0);
        rdy <= 1'b1;
        @(negedge clk_i);
        acc(1'b0, 7'h32, 8'h03, 1'b0);
        acc(1'b1, 7'h33, 8'h00, 1'b0);
        acc(1'b1, 7'h33, 8'h01, 1'b0);
        repeat (3) @(negedge clk_i);
        chk("latches", 8'h01, n_lat[7:0]);
    endtask
    task automatic conclude();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        t_reset(1'b0, 8'h38);
        t_page();
        t_lock();
        t_cfg();
        t_reset(1'b1, 8'h2a);
        conclude();
    end
endmodule
`default_nettype wire
